// [acsr_bank.sv]
// APB register bank holding accumulator source images and identity codes
`timescale 1ns/10ps
`default_nettype none
module acsr_bank #(
    parameter int unsigned ADDR_W = 12,
    parameter int unsigned SETTLE_CYC = acsr_pkg::RESULT_SETTLE_CYC,
    parameter logic [7:0] PRODUCT_CODE = acsr_pkg::PRODUCT_CODE_DEF,
    parameter logic [7:0] VENDOR_CODE = acsr_pkg::VENDOR_CODE_DEF,
    parameter logic [7:0] DIE_REVISION = acsr_pkg::DIE_REVISION_DEF
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [acsr_pkg::DATA_W-1:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [acsr_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire acsr_pkg::acsr_img_t STAGED_SEL,
    input wire logic REFRESH,
    output acsr_pkg::acsr_img_t ACTIVE_SEL,
    output acsr_pkg::acsr_img_t PREV_SEL,
    output logic RESULT_VALID
);
    // Settle end count, cut to the counter width once
    localparam logic [31:0] SETTLE_LAST =
        32'(SETTLE_CYC) - acsr_pkg::CNT_ONE;

    acsr_pkg::acsr_state_t st_ff;
    acsr_pkg::acsr_state_t nxt_st;

    acsr_pkg::acsr_img_t staged_clean;
    acsr_pkg::acsr_img_t wdata_img;
    acsr_pkg::acsr_img_t wdata_clean;

    logic setup_ph;
    logic access_ph;
    logic wr_fire;
    logic wr_lane;
    logic hit_any;
    logic [31:0] rd_word;
    logic [31:0] status_word;

    // True when the byte address selects the word at the given index
    function automatic logic reg_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [acsr_pkg::IDX_W-1:0] idx
    );
        logic [ADDR_W-1:0] want;
        want = '0;
        want[acsr_pkg::IDX_LSB +: acsr_pkg::IDX_W] = idx;
        reg_hit = (addr == want);
    endfunction

    // Places an 8-bit value in the low byte of a bus word
    function automatic logic [31:0] low_byte(
        input logic [7:0] val
    );
        logic [31:0] word;
        word = acsr_pkg::WORD_ZERO;
        word[acsr_pkg::IMG_W-1:0] = val;
        low_byte = word;
    endfunction

    // Reserved codes are folded before anything is stored
    acsr_img_clean #(
        .NUM_CH(acsr_pkg::NUM_CH)
    ) u_clean_staged (
        .img_in(STAGED_SEL),
        .img_out(staged_clean)
    );

    // Host write data path goes through the same fold
    assign wdata_img = PWDATA[acsr_pkg::IMG_W-1:0];
    acsr_img_clean #(
        .NUM_CH(acsr_pkg::NUM_CH)
    ) u_clean_wdata (
        .img_in(wdata_img),
        .img_out(wdata_clean)
    );

    // Bus phase decode
    assign setup_ph = PSEL & ~PENABLE;
    assign access_ph = PSEL & PENABLE;
    assign wr_lane = PSTRB[acsr_pkg::STRB_LOW];
    assign wr_fire = access_ph & PWRITE & wr_lane;

    // Known addresses of the bank
    assign hit_any = reg_hit(PADDR, acsr_pkg::IDX_ACTIVE) |
        reg_hit(PADDR, acsr_pkg::IDX_PREVIOUS) |
        reg_hit(PADDR, acsr_pkg::IDX_STATUS) |
        reg_hit(PADDR, acsr_pkg::IDX_PRODUCT) |
        reg_hit(PADDR, acsr_pkg::IDX_VENDOR) |
        reg_hit(PADDR, acsr_pkg::IDX_REVISION);

    // Status word shows whether the results of the active image are valid or still settling
    always_comb begin
        status_word = acsr_pkg::WORD_ZERO;
        status_word[acsr_pkg::STATUS_VALID_BIT] =
            (st_ff.fsm == acsr_pkg::ACSR_ST_VALID);
        status_word[acsr_pkg::STATUS_SETTLE_BIT] =
            (st_ff.fsm == acsr_pkg::ACSR_ST_SETTLE);
    end

    // Read multiplexer; unknown addresses read as zero
    always_comb begin
        rd_word = acsr_pkg::WORD_ZERO;
        if (reg_hit(PADDR, acsr_pkg::IDX_ACTIVE)) begin
            rd_word = low_byte(st_ff.active);
        end else if (reg_hit(PADDR, acsr_pkg::IDX_PREVIOUS)) begin
            rd_word = low_byte(st_ff.previous);
        end else if (reg_hit(PADDR, acsr_pkg::IDX_STATUS)) begin
            rd_word = status_word;
        end else if (reg_hit(PADDR, acsr_pkg::IDX_PRODUCT)) begin
            rd_word = low_byte(PRODUCT_CODE);
        end else if (reg_hit(PADDR, acsr_pkg::IDX_VENDOR)) begin
            rd_word = low_byte(VENDOR_CODE);
        end else if (reg_hit(PADDR, acsr_pkg::IDX_REVISION)) begin
            rd_word = low_byte(DIE_REVISION);
        end
    end

    // Next-state logic for the whole bank
    always_comb begin
        nxt_st = st_ff;

        // Read data and error are caught in the setup cycle
        if (setup_ph) begin
            nxt_st.rdata = rd_word;
            nxt_st.slverr = ~hit_any;
        end

        // Host writes; identity and status words have no storage
        if (wr_fire & hit_any) begin
            if (reg_hit(PADDR, acsr_pkg::IDX_ACTIVE)) begin
                nxt_st.active = wdata_clean;
            end
            if (reg_hit(PADDR, acsr_pkg::IDX_PREVIOUS)) begin
                nxt_st.previous = wdata_clean;
            end
            // Writes to the identity words fall through unused
        end

        // Refresh wins over a host write in the same cycle
        if (REFRESH) begin
            // Old active selection moves out first
            nxt_st.previous = st_ff.active;
            // Then the staged selection comes into force
            nxt_st.active = staged_clean;
        end

        // Settle tracking of the result set
        case (st_ff.fsm)
            acsr_pkg::ACSR_ST_VALID: begin
                if (REFRESH) begin
                    nxt_st.fsm = acsr_pkg::ACSR_ST_SETTLE;
                    nxt_st.wait_cnt = acsr_pkg::CNT_ZERO;
                end
            end
            acsr_pkg::ACSR_ST_SETTLE: begin
                if (REFRESH) begin
                    // A new refresh restarts the wait
                    nxt_st.wait_cnt = acsr_pkg::CNT_ZERO;
                end else if (st_ff.wait_cnt >= SETTLE_LAST) begin
                    nxt_st.fsm = acsr_pkg::ACSR_ST_VALID;
                    nxt_st.wait_cnt = acsr_pkg::CNT_ZERO;
                end else begin
                    nxt_st.wait_cnt = st_ff.wait_cnt + acsr_pkg::CNT_ONE;
                end
            end
            default: begin
                nxt_st.fsm = acsr_pkg::ACSR_ST_VALID;
                nxt_st.wait_cnt = acsr_pkg::CNT_ZERO;
            end
        endcase
    end

    // State register with synchronous reset to power defaults
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            st_ff.active <= acsr_pkg::IMG_RESET;
            st_ff.previous <= acsr_pkg::IMG_RESET;
            st_ff.fsm <= acsr_pkg::ACSR_ST_VALID;
            st_ff.wait_cnt <= acsr_pkg::CNT_ZERO;
            st_ff.rdata <= acsr_pkg::WORD_ZERO;
            st_ff.slverr <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Zero-wait slave: the access phase always completes at once
    assign PREADY = 1'b1;
    assign PRDATA = st_ff.rdata;
    assign PSLVERR = access_ph & st_ff.slverr;

    // Selections that steer the accumulators
    assign ACTIVE_SEL = st_ff.active;
    assign PREV_SEL = st_ff.previous;
    assign RESULT_VALID = (st_ff.fsm == acsr_pkg::ACSR_ST_VALID);
endmodule
`default_nettype wire

// [acsr_pkg.sv]
// Shared constants, types and register map of the source image bank
`default_nettype none
package acsr_pkg;
    // Bus and image widths
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IMG_W = 8;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned SRC_W = 2;
    localparam int unsigned CNT_W = 32;

    // Accumulator source codes
    localparam logic [1:0] SRC_POWER = 2'h0;
    localparam logic [1:0] SRC_SHUNT = 2'h1;
    localparam logic [1:0] SRC_RAIL = 2'h2;
    localparam logic [1:0] SRC_RSVD = 2'h3;

    // Register indices; byte address is four times the index
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_W = 8;
    localparam logic [1:0] WORD_ALIGN = 2'h0;
    localparam logic [7:0] IDX_ACTIVE = 8'h4A;
    localparam logic [7:0] IDX_PREVIOUS = 8'h4B;
    localparam logic [7:0] IDX_STATUS = 8'h4C;
    localparam logic [7:0] IDX_PRODUCT = 8'hFD;
    localparam logic [7:0] IDX_VENDOR = 8'hFE;
    localparam logic [7:0] IDX_REVISION = 8'hFF;

    // Reset values and status fields
    localparam logic [7:0] IMG_RESET = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;
    localparam int unsigned STATUS_VALID_BIT = 0;
    localparam int unsigned STATUS_SETTLE_BIT = 1;
    localparam int unsigned STRB_LOW = 0;

    // Identification values; all three values are arbitrary
    localparam logic [7:0] PRODUCT_CODE_DEF = 8'hA5;
    localparam logic [7:0] VENDOR_CODE_DEF = 8'h3C;
    localparam logic [7:0] DIE_REVISION_DEF = 8'h11;

    // Result settle time after a refresh
    localparam int unsigned CLK_FREQ_KHZ = 250000;
    localparam int unsigned RESULT_SETTLE_MS = 1;
    localparam int unsigned RESULT_SETTLE_CYC =
        RESULT_SETTLE_MS * CLK_FREQ_KHZ;

    // One source-selection image; channel 1 sits in the top bits
    typedef struct packed {
        logic [1:0] ch1_accum_source_sel;
        logic [1:0] ch2_accum_source_sel;
        logic [1:0] ch3_accum_source_sel;
        logic [1:0] ch4_accum_source_sel;
    } acsr_img_t;

    // Settle tracking states
    typedef enum logic [1:0] {
        ACSR_ST_VALID = 2'b01,
        ACSR_ST_SETTLE = 2'b10
    } acsr_fsm_t;

    // Whole state of the bank
    typedef struct packed {
        acsr_img_t active;
        acsr_img_t previous;
        acsr_fsm_t fsm;
        logic [31:0] wait_cnt;
        logic [31:0] rdata;
        logic slverr;
    } acsr_state_t;
endpackage
`default_nettype wire

// [acsr_img_clean.sv]
// Maps reserved source codes in an image to the power selection
`timescale 1ns/10ps
`default_nettype none
module acsr_img_clean #(
    parameter int unsigned NUM_CH = acsr_pkg::NUM_CH
) (
    input wire acsr_pkg::acsr_img_t img_in,
    output acsr_pkg::acsr_img_t img_out
);
    logic [acsr_pkg::IMG_W-1:0] raw;
    logic [acsr_pkg::IMG_W-1:0] clean;

    assign raw = img_in;

    // Each two-bit field is checked on its own
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
            localparam int unsigned LSB = ch * acsr_pkg::SRC_W;
            // Reserved code is replaced by the power code, so it is stored and read back as zero
            assign clean[LSB +: acsr_pkg::SRC_W] =
                (raw[LSB +: acsr_pkg::SRC_W] == acsr_pkg::SRC_RSVD) ?
                acsr_pkg::SRC_POWER :
                raw[LSB +: acsr_pkg::SRC_W];
        end
    endgenerate

    assign img_out = clean;
endmodule
`default_nettype wire

// [acsr_bank_properties.sv]
// Port-level checker of the source image bank
`timescale 1ns/10ps
`default_nettype none
module acsr_bank_properties #(
    parameter int unsigned ADDR_W = 12,
    parameter int unsigned SETTLE_CYC = 8,
    parameter logic [7:0] PRODUCT_CODE = 8'h00,
    parameter logic [7:0] VENDOR_CODE = 8'h00,
    parameter logic [7:0] DIE_REVISION = 8'h00
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [acsr_pkg::DATA_W-1:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [acsr_pkg::DATA_W-1:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire acsr_pkg::acsr_img_t STAGED_SEL,
    input wire logic REFRESH,
    input wire acsr_pkg::acsr_img_t ACTIVE_SEL,
    input wire acsr_pkg::acsr_img_t PREV_SEL,
    input wire logic RESULT_VALID
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    logic [7:0] rsv_m, stg_fold;
    logic [31:0] since_ff;
    logic wr_on;
    // Staged image with reserved codes cleared to power
    assign rsv_m = STAGED_SEL & (STAGED_SEL >> 1) & 8'h55;
    assign stg_fold = STAGED_SEL & ~(rsv_m | (rsv_m << 1));
    assign wr_on = PSEL && PENABLE && PWRITE && PSTRB[0];
    // Cycles since the last refresh edge, stops past the settle time
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || REFRESH) begin
            since_ff <= {31'h0, RST_N};
        end else if (since_ff != 32'h0 && since_ff <= SETTLE_CYC) begin
            since_ff <= since_ff + 32'h1;
        end
    end
    AST_REF_PREV: assert property (
        REFRESH |=> PREV_SEL == $past(ACTIVE_SEL))
        else $error("previous image not taken on refresh");
    AST_REF_ACT: assert property (
        REFRESH |=> ACTIVE_SEL == $past(stg_fold))
        else $error("active image not loaded on refresh");
    AST_NO_RSVD: assert property (
        !(|(ACTIVE_SEL & (ACTIVE_SEL >> 1) & 8'h55)))
        else $error("reserved code held in active image");
    AST_VALID_LOW: assert property (
        since_ff != 32'h0 && since_ff <= SETTLE_CYC |-> !RESULT_VALID)
        else $error("results valid too early");
    AST_VALID_BACK: assert property (
        since_ff == SETTLE_CYC + 1 |-> RESULT_VALID)
        else $error("results not valid after settle time");
    AST_ID_READ: assert property (
        PSEL && !PENABLE && PADDR == 12'h3F4
        |=> PRDATA == {24'h0, PRODUCT_CODE})
        else $error("product code read wrong");
    AST_VENDOR_READ: assert property (
        PSEL && !PENABLE && PADDR == 12'h3F8
        |=> PRDATA == {24'h0, VENDOR_CODE})
        else $error("vendor code read wrong");
    AST_REV_READ: assert property (
        PSEL && !PENABLE && PADDR == 12'h3FC
        |=> PRDATA == {24'h0, DIE_REVISION})
        else $error("die revision read wrong");
    AST_ACT_HOLD: assert property (
        !REFRESH && !(wr_on && PADDR == 12'h128) |=> $stable(ACTIVE_SEL))
        else $error("active image changed without cause");
    AST_PREV_HOLD: assert property (
        !REFRESH && !(wr_on && PADDR == 12'h12C) |=> $stable(PREV_SEL))
        else $error("previous image changed without cause");
endmodule
bind acsr_bank acsr_bank_properties #(.ADDR_W(ADDR_W),
    .SETTLE_CYC(SETTLE_CYC), .PRODUCT_CODE(PRODUCT_CODE),
    .VENDOR_CODE(VENDOR_CODE), .DIE_REVISION(DIE_REVISION))
    acsr_bank_properties_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .STAGED_SEL(STAGED_SEL), .REFRESH(REFRESH),
    .ACTIVE_SEL(ACTIVE_SEL), .PREV_SEL(PREV_SEL),
    .RESULT_VALID(RESULT_VALID));
`default_nettype wire

// [acsr_stage_src.sv]
// Staging source model that presents staged selections and refresh pulses
`timescale 1ns/10ps
`default_nettype none
module acsr_stage_src (
    input wire logic clk,
    input wire logic rst_n,
    input wire acsr_pkg::acsr_img_t stg_in,
    input wire logic go,
    output acsr_pkg::acsr_img_t staged,
    output logic refresh
);
    // Staged image steady across the refresh edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            staged <= 8'h00;
            refresh <= 1'b0;
        end else begin
            staged <= stg_in;
            refresh <= go;
        end
    end
endmodule
`default_nettype wire

// [acsr_bank_tb_top.sv]
// Self-checking bench of the source image bank
`timescale 1ns/10ps
`default_nettype none
module acsr_bank_tb_top;
    localparam int unsigned SETTLE = 8;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, go = 1'b0, pready, pslverr, refresh, rvalid;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hF;
    acsr_pkg::acsr_img_t stg = 8'h00, staged, act, prev;
    int n_mismatch = 0;
    int tests_run = 0;
    always #2 clk = ~clk;
    acsr_bank #(.SETTLE_CYC(SETTLE)) acsr_bank_i (.CORE_CLK(clk),
        .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .STAGED_SEL(staged),
        .REFRESH(refresh), .ACTIVE_SEL(act), .PREV_SEL(prev),
        .RESULT_VALID(rvalid));
    acsr_stage_src acsr_stage_src_i (.clk(clk), .rst_n(rst_n),
        .stg_in(stg), .go(go), .staged(staged), .refresh(refresh));
    // Compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; answer taken at the ready edge, then released
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
            input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    // Reserved codes become power
    function automatic logic [7:0] fold(input logic [7:0] v);
        fold = v;
        for (int i = 0; i < 8; i += 2) begin
            if (v[i +: 2] == 2'h3) fold[i +: 2] = 2'h0;
        end
    endfunction
    // Refresh held for reps cycles, then time the settle wait
    task automatic pulse(input logic [7:0] s, input int reps);
        int n;
        stg <= s;
        go <= 1'b1;
        repeat (reps) @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        chk(32'(n), 32'(SETTLE + 1));
    endtask
    // Reset images, identity codes, identity writes, unmapped place
    task automatic t_ids();
        rd(12'h128, 32'h0, 1'b0);
        rd(12'h12C, 32'h0, 1'b0);
        for (int i = 1; i < 4; i++) begin
            wr(12'h3F0 + 12'(4 * i), 32'hFF);
        end
        rd(12'h3F4, {24'h0, acsr_pkg::PRODUCT_CODE_DEF}, 1'b0);
        rd(12'h3F8, {24'h0, acsr_pkg::VENDOR_CODE_DEF}, 1'b0);
        rd(12'h3FC, {24'h0, acsr_pkg::DIE_REVISION_DEF}, 1'b0);
        rd(12'h200, 32'h0, 1'b1);
    endtask
    // Every code on every channel, staged values wait for refresh
    task automatic t_refresh();
        logic [7:0] s, old;
        old = 8'h00;
        for (int k = 0; k < 4; k++) begin
            s = {2'(k), 2'(k + 1), 2'(k + 2), 2'(k + 3)};
            stg <= s;
            repeat (3) @(posedge clk);
            rd(12'h128, {24'h0, old}, 1'b0);
            pulse(s, 1);
            rd(12'h128, {24'h0, fold(s)}, 1'b0);
            rd(12'h12C, {24'h0, old}, 1'b0);
            chk({24'h0, act}, {24'h0, fold(s)});
            chk({24'h0, prev}, {24'h0, old});
            old = fold(s);
        end
        pulse(8'h26, 2);
        rd(12'h12C, 32'h26, 1'b0);
    endtask
    // Host writes fold reserved codes; low strobe drops the write
    task automatic t_write();
        wr(12'h128, 32'h9B);
        rd(12'h128, 32'h98, 1'b0);
        pstrb <= 4'hE;
        wr(12'h128, 32'h11);
        pstrb <= 4'hF;
        rd(12'h128, 32'h98, 1'b0);
        wr(12'h12C, 32'hE7);
        rd(12'h12C, 32'h24, 1'b0);
    endtask
    // Settling flag in status, then a mid-run reset
    task automatic t_reset();
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        rd(12'h130, 32'h2, 1'b0);
        repeat (SETTLE) @(posedge clk);
        rd(12'h130, 32'h1, 1'b0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(12'h128, 32'h0, 1'b0);
        rd(12'h12C, 32'h0, 1'b0);
        rd(12'h130, 32'h1, 1'b0);
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_ids();
        t_refresh();
        t_write();
        t_reset();
        print_verdict();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
